// [core/spog_gate.sv]
// Sideband bus output gate held floating through power-up
`timescale 1ns/100ps
module spog_gate
    import spog_pkg::*;
#(
    parameter int unsigned W          = 2,
    parameter int unsigned N_RST      = 1,
    parameter bit          USE_SUPPLY = 1'b1,
    parameter bit          USE_RESET  = 1'b1,
    parameter bit          USE_REFCLK = 1'b1
) (
    // System clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Sideband reference clock
    input  wire logic             ref_clk,
    // Start-up pins, asynchronous
    input  wire logic             supply_good,
    input  wire logic [N_RST-1:0] startup_rst_n,
    // Core side, reference clock domain
    input  wire logic [W-1:0]     core_txd,
    input  wire logic             core_oe_req,
    // Pad side, reference clock domain
    output logic      [W-1:0]     pad_o,
    output logic      [W-1:0]     pad_oe,
    // Status, system clock domain
    output logic                  float_done,
    output logic                  refclk_seen
);

    typedef struct packed {
        logic             rst_s1;
        logic             rst_s2;
        logic             rdy_s1;
        logic             rdy_s2;
        logic [CNT_W-1:0] det_cnt;
        logic             det_done;
        logic [CNT_W-1:0] flt_cnt;
        logic             gate_open;
        logic [W-1:0]     pad_o;
        logic [W-1:0]     pad_oe;
    } spog_gate_s;

    spog_gate_s       r;
    spog_gate_s       next_r;
    logic             det_ok;
    logic             arm;
    logic [CNT_W-1:0] open_age;

    spog_xdom_if xif ();

    // System-clock hold-off for supply and reset sources
    spog_sys_holdoff #(
        .N_RST      (N_RST),
        .USE_SUPPLY (USE_SUPPLY),
        .USE_RESET  (USE_RESET)
    ) u_hold (
        .clock         (clock),
        .rst           (rst),
        .supply_good   (supply_good),
        .startup_rst_n (startup_rst_n),
        .xif           (xif)
    );

    // Detection counts only when that source is selected
    assign det_ok = !USE_REFCLK || r.det_done;
    // Float runs only while every selected source is released
    assign arm    = det_ok && r.rdy_s2;

    // Reference-domain state
    always_comb begin
        next_r        = r;
        // Reset comes from the system clock, so it is resynchronised
        next_r.rst_s1 = rst;
        next_r.rst_s2 = r.rst_s1;
        // Hold-off level crossing, read only after the second stage
        next_r.rdy_s1 = xif.sys_ready;
        next_r.rdy_s2 = r.rdy_s1;
        if (r.rst_s2) begin
            next_r.det_cnt   = CNT_RST;
            next_r.det_done  = FLAG_RST;
            next_r.flt_cnt   = CNT_RST;
            next_r.gate_open = FLAG_RST;
            next_r.pad_o     = '0;
            next_r.pad_oe    = '0;
        end else begin
            // Clock presence: count edges once after reset
            if (!r.det_done) begin
                next_r.det_cnt = spog_sat_inc(r.det_cnt);
                if (spog_hit(r.det_cnt, REF_DETECT_CYC)) begin
                    next_r.det_done = 1'b1;
                end
            end
            // Further float after detection and hold-off release
            if (!arm) begin
                next_r.flt_cnt   = CNT_RST;
                next_r.gate_open = FLAG_RST;
            end else if (!r.gate_open) begin
                next_r.flt_cnt = spog_sat_inc(r.flt_cnt);
                if (spog_hit(r.flt_cnt, FLOAT_REF_CYC)) begin
                    next_r.gate_open = 1'b1;
                end
            end
            // Pads stay floating and quiet until the gate opens
            next_r.pad_oe = {W{r.gate_open && core_oe_req}};
            next_r.pad_o  = r.gate_open ? core_txd : '0;
        end
    end

    // One register stage for the whole reference-domain state
    always_ff @(posedge ref_clk) begin
        r <= next_r;
    end

    // Outputs straight from flip-flops
    assign pad_o        = r.pad_o;
    assign pad_oe       = r.pad_oe;
    assign xif.det_done = r.det_done;
    assign float_done   = xif.sys_ready;
    assign refclk_seen  = xif.refclk_seen;

    // Helper for checks: cycles with the float armed
    always_ff @(posedge ref_clk) begin
        if (r.rst_s2 || !arm) begin
            open_age <= CNT_RST;
        end else begin
            open_age <= spog_sat_inc(open_age);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (r.rst_s2);

    // Drive only after a full armed interval
    // Pads trail the gate by one edge, so the age is taken one edge back
    a_oe_after_float: assert property (|r.pad_oe |-> $past(open_age) >= FLOAT_REF_CYC)
        else $error("pad enabled before reference float interval");

    // Drive only after clock presence was counted
    a_detect_before_oe: assert property (|r.pad_oe |-> (!USE_REFCLK || r.det_cnt >= REF_DETECT_CYC))
        else $error("pad enabled before clock detection");

    // Loss of hold-off closes the gate and then the pads
    a_holdoff_drop: assert property ($fell(r.rdy_s2) |=> !r.gate_open ##1 (r.pad_oe == '0))
        else $error("pads not floated after hold-off dropped");

    // Selected sources must all agree before any drive
    // Gate then pads add two edges behind the synchronised hold-off
    a_sources_agree: assert property (|r.pad_oe |-> $past(r.rdy_s2, 2))
        else $error("pad enabled without system hold-off");

    // Pads enable only from an open gate
    a_oe_needs_gate: assert property (|r.pad_oe |-> $past(r.gate_open))
        else $error("pad enabled while gate closed");

    // Closed gate leaves the pads floating and quiet
    a_quiet_closed: assert property (!r.gate_open |=> (r.pad_o == '0) && (r.pad_oe == '0))
        else $error("pad active after gate closed");

    // Enables switch as one group
    a_pad_bits_equal: assert property (|r.pad_oe |-> &r.pad_oe)
        else $error("pad enables disagree");

    // Open gate passes core inputs with one edge of latency
    a_pad_follow: assert property (r.gate_open |=> (r.pad_oe == {W{$past(core_oe_req)}})
        && (r.pad_o == $past(core_txd)))
        else $error("pads do not follow core inputs");

    // Detection is counted once and then held
    a_det_sticky: assert property (r.det_done |=> r.det_done)
        else $error("clock detection lost");

    // Detection ends on the last counted edge
    a_det_at_count: assert property ($rose(r.det_done) |-> r.det_cnt == REF_DETECT_CYC)
        else $error("clock detection at wrong count");

    // Gate never opens ahead of detection
    a_det_before_gate: assert property (r.gate_open |-> (!USE_REFCLK || r.det_done))
        else $error("gate open before clock detection");

    // Gate stays open only while armed
    a_gate_needs_arm: assert property (r.gate_open |-> $past(arm))
        else $error("gate open while not armed");

    // Gate opens exactly at the end of the armed float
    a_gate_at_count: assert property ($rose(r.gate_open) |-> open_age == FLOAT_REF_CYC)
        else $error("gate open at wrong float count");

    // Losing arm restarts the float from zero
    a_flt_cleared: assert property (!arm |=> r.flt_cnt == CNT_RST)
        else $error("float count kept after disarm");

    // Losing arm closes the gate on the next edge
    a_gate_drop: assert property (!arm |=> !r.gate_open)
        else $error("gate kept open after disarm");

    c_gate_opens: cover property ($rose(r.gate_open));
    c_pad_drive: cover property ($rose(|r.pad_oe));
    c_detect_done: cover property ($rose(r.det_done));

endmodule : spog_gate

// [core/spog_pkg.sv]
// Shared constants and helpers for the sideband power-up output gate
package spog_pkg;

    // Counter width used by every hold-off counter
    localparam int unsigned CNT_W          = 9;

    // Float interval, as a time and as cycles of each clock
    localparam int unsigned FLOAT_NS       = 2000;
    localparam int unsigned SYS_CLK_MHZ    = 125;
    localparam int unsigned REF_CLK_MHZ    = 50;
    localparam int unsigned FLOAT_SYS_CYC  = (FLOAT_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int unsigned FLOAT_REF_CYC  = (FLOAT_NS * REF_CLK_MHZ + 999) / 1000;

    // Reference clock edges counted before the clock counts as present
    localparam int unsigned REF_DETECT_CYC = 100;

    // Longest start-up time allowed to the reference clock source
    localparam int unsigned CLK_STARTUP_MS = 100;

    // Values after reset
    localparam logic [CNT_W-1:0] CNT_RST   = 9'h000;
    localparam logic             FLAG_RST  = 1'b0;

    // True when a counter sits on the last cycle of an interval of n cycles
    function automatic logic spog_hit(input logic [CNT_W-1:0] c, input int unsigned n);
        return c == CNT_W'(n - 1);
    endfunction : spog_hit

    // Counter step that stops at all ones
    function automatic logic [CNT_W-1:0] spog_sat_inc(input logic [CNT_W-1:0] c);
        return (&c) ? c : c + CNT_W'(1);
    endfunction : spog_sat_inc

endpackage : spog_pkg

// [core/spog_sys_holdoff.sv]
// System-clock hold-off after supply good and start-up reset release
`timescale 1ns/100ps
module spog_sys_holdoff
    import spog_pkg::*;
#(
    parameter int unsigned N_RST      = 1,
    parameter bit          USE_SUPPLY = 1'b1,
    parameter bit          USE_RESET  = 1'b1
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Start-up pins, asynchronous
    input  wire logic             supply_good,
    input  wire logic [N_RST-1:0] startup_rst_n,
    // Crossing to the reference clock side
    spog_xdom_if.hold             xif
);

    typedef struct packed {
        logic             sup_s1;
        logic             sup_s2;
        logic [N_RST-1:0] rn_s1;
        logic [N_RST-1:0] rn_s2;
        logic             seen_s1;
        logic             seen_s2;
        logic [CNT_W-1:0] cnt;
        logic             ready;
    } spog_hold_s;

    spog_hold_s r;
    spog_hold_s next_r;
    logic       qualify;
    logic [CNT_W-1:0] qual_age;

    // Every selected start-up source must be released
    assign qualify = (!USE_SUPPLY || r.sup_s2) && (!USE_RESET || (&r.rn_s2));

    // Synchronisers and float counter
    always_comb begin
        next_r         = r;
        next_r.sup_s1  = supply_good;
        next_r.sup_s2  = r.sup_s1;
        next_r.rn_s1   = startup_rst_n;
        next_r.rn_s2   = r.rn_s1;
        next_r.seen_s1 = xif.det_done;
        next_r.seen_s2 = r.seen_s1;
        if (rst || !qualify) begin
            // Any source dropping restarts the whole interval
            next_r.cnt   = CNT_RST;
            next_r.ready = FLAG_RST;
        end else if (!r.ready) begin
            next_r.cnt = spog_sat_inc(r.cnt);
            if (spog_hit(r.cnt, FLOAT_SYS_CYC)) begin
                next_r.ready = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        r <= next_r;
    end

    assign xif.sys_ready   = r.ready;
    assign xif.refclk_seen = r.seen_s2;

    // Helper for checks: cycles of continuous qualification
    always_ff @(posedge clock) begin
        if (rst || !qualify) begin
            qual_age <= CNT_RST;
        end else begin
            qual_age <= spog_sat_inc(qual_age);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_ready_after_float: assert property (r.ready |-> qual_age >= FLOAT_SYS_CYC)
        else $error("hold-off ready before float interval");
    a_ready_exact_time: assert property ($rose(r.ready) |-> qual_age == FLOAT_SYS_CYC)
        else $error("hold-off ready not at float interval");
    a_any_reset_held: assert property (USE_RESET && !(&r.rn_s2) |=> !r.ready)
        else $error("ready while a start-up reset is held");

    c_ready_seen: cover property ($rose(r.ready));
    c_reset_release: cover property ($rose(&r.rn_s2) ##[1:300] r.ready);

endmodule : spog_sys_holdoff

// [core/spog_xdom_if.sv]
// Levels passed between the system-clock hold-off and the reference-clock gate
`timescale 1ns/100ps
interface spog_xdom_if;
    logic sys_ready;   // System clock: supply and reset hold-off complete
    logic refclk_seen; // System clock: reference clock detection seen
    logic det_done;    // Reference clock: detection count complete

    modport hold (output sys_ready, output refclk_seen, input det_done);
    modport gate (input sys_ready, input refclk_seen, output det_done);
endinterface : spog_xdom_if

// [sim/spog_mc_model.sv]
// Management controller and power logic model driving the start-up pins
`timescale 1ns/100ps
module spog_mc_model (
    // Bench commands
    input  wire logic       clk_run,
    input  wire logic       pwr_req,
    input  wire logic       rel_req,
    // Pins seen by the device
    output logic            ref_clk,
    output logic            supply_good,
    output logic [0:0]      startup_rst_n
);
    // Clock stands still low while stopped; odd offset keeps it unrelated in phase
    initial begin
        ref_clk = 1'b0;
        #13;
        forever begin
            #32;
            ref_clk = clk_run ? ~ref_clk : 1'b0;
        end
    end

    // One shared release, held asserted whenever supply is off
    assign supply_good   = pwr_req;
    assign startup_rst_n = rel_req & pwr_req;
endmodule : spog_mc_model

// [sim/tb_top.sv]
// Self-checking bench for the power-up output gate
`timescale 1ns/100ps
module tb_top;
    import spog_pkg::*;
    logic       clock, rst, ref_clk, supply_good, core_oe_req, float_done, refclk_seen;
    logic       clk_run, pwr_req, rel_req, prev_oe;
    logic [0:0] startup_rst_n;
    logic [1:0] core_txd, pad_o, pad_oe, prev_txd;
    int         fails, n_compared, n, ref_n;

    spog_mc_model mc (.clk_run(clk_run), .pwr_req(pwr_req), .rel_req(rel_req),
        .ref_clk(ref_clk), .supply_good(supply_good), .startup_rst_n(startup_rst_n));
    spog_gate uut (.clock(clock), .rst(rst), .ref_clk(ref_clk), .supply_good(supply_good),
        .startup_rst_n(startup_rst_n), .core_txd(core_txd), .core_oe_req(core_oe_req),
        .pad_o(pad_o), .pad_oe(pad_oe), .float_done(float_done), .refclk_seen(refclk_seen));

    // System clock, 8 ns
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Reference edges since the clock was last started
    always @(posedge ref_clk) ref_n <= ref_n + 1;

    // Pads while open follow the previous edge's core inputs
    function automatic logic [3:0] exp_pad(input logic open, input logic oe, input logic [1:0] txd);
        return open ? {{2{oe}}, txd} : 4'h0;
    endfunction : exp_pad

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("compared=%0d fails=%0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    // Bounded wait: 0 float_done, 1 pad_oe
    task automatic wait_for(input int which, input int lim, output int cyc);
        cyc = 0;
        while (!((which == 0) ? (float_done === 1'b1) : (pad_oe[0] === 1'b1))) begin
            @(posedge clock);
            cyc++;
            if (cyc > lim) begin
                fails++;
                end_sim();
            end
        end
    endtask : wait_for

    initial begin
        rst = 1'b1; clk_run = 1'b1; pwr_req = 1'b0; rel_req = 1'b0;
        core_txd = 2'h0; core_oe_req = 1'b1; fails = 0; n_compared = 0; ref_n = 0;
        n = $urandom(32'h7351);
        // Long enough for the reference side to see reset as well
        repeat (40) @(posedge clock);
        rst <= 1'b0;
        clk_run <= 1'b0;
        repeat (600) @(posedge clock);
        chk(float_done, 1'b0);
        chk(pad_oe, 2'h0);
        // Supply alone is not enough while start-up reset is held
        pwr_req <= 1'b1;
        repeat (400) @(posedge clock);
        chk(float_done, 1'b0);
        rel_req <= 1'b1;
        repeat (120) @(posedge clock);
        rel_req <= 1'b0;
        @(posedge clock);
        rel_req <= 1'b1;
        wait_for(0, 400, n);
        chk(n >= FLOAT_SYS_CYC && n <= FLOAT_SYS_CYC + 3, 1'b1);
        // Clock still stopped: gate must stay shut
        repeat (50) @(posedge clock);
        chk(refclk_seen, 1'b0);
        chk(pad_oe, 2'h0);
        ref_n = 0;
        clk_run <= 1'b1;
        wait_for(1, 2000, n);
        chk(ref_n >= REF_DETECT_CYC + FLOAT_REF_CYC && ref_n <= REF_DETECT_CYC + FLOAT_REF_CYC + 12, 1'b1);
        chk(refclk_seen, 1'b1);
        // Random traffic through the open gate
        repeat (40) begin
            @(posedge ref_clk);
            prev_oe = core_oe_req;
            prev_txd = core_txd;
            core_txd <= 2'($urandom);
            core_oe_req <= 1'($urandom);
            #1 chk({pad_oe, pad_o}, exp_pad(1'b1, prev_oe, prev_txd));
        end
        // Supply drop closes the gate even with the core asking to drive
        core_oe_req <= 1'b1;
        @(posedge clock);
        pwr_req <= 1'b0;
        repeat (5) @(posedge clock);
        chk(float_done, 1'b0);
        repeat (6) @(posedge ref_clk);
        #1 chk({pad_oe, pad_o}, exp_pad(1'b0, 1'b1, core_txd));
        end_sim();
    end
endmodule : tb_top
